// *** design/file_alu.sv ***
// Purpose: execution datapath for rotate, subtract, swap, direction load, xor and power-down
// Assumes: decoder holds one operation at a time and waits for O_READY
// Notes: software reaches accumulator, status, direction and file space over a byte port
`timescale 1ns/1ps
module file_alu
  import file_alu_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // operation from the decoder
  input wire logic I_OP_VALID,
  input wire file_alu_pkg::op_t I_OP,
  input wire logic [file_alu_pkg::FILE_AW-1:0] I_OP_ADDR,
  input wire logic I_OP_TARGET,
  input wire logic [file_alu_pkg::DATA_W-1:0] I_OP_LITERAL,
  // wake-up event pin
  input wire logic I_WAKE,
  // register port
  input wire logic [file_alu_pkg::BUS_AW-1:0] I_ADDR,
  input wire logic [file_alu_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [file_alu_pkg::DATA_W-1:0] O_RDATA,
  // datapath state
  output logic [file_alu_pkg::DATA_W-1:0] O_ACC,
  output logic [file_alu_pkg::DATA_W-1:0] O_STATUS,
  output logic [file_alu_pkg::DATA_W-1:0] O_DIR,
  output logic O_OSC_HALT,
  output logic O_READY,
  output logic O_DONE
);

  import file_alu_pkg::*;

  typedef struct packed {
    state_t st;
    op_t op;
    logic [FILE_AW-1:0] addr;
    logic tgt;
    logic [DATA_W-1:0] acc;
    logic arith_out_bit;
    logic nibble_out_bit;
    logic all_bits_nil_flag;
    logic powerdown_flag;
    logic watchdog_expiry_flag;
    logic [DATA_W-1:0] dir;
    logic [DATA_W-1:0] watchdog_counter;
    logic [DATA_W-1:0] presc;
    logic watchdog_enable;
    logic [1:0] wake_sync;
    logic ready;
    logic done;
    logic halt;
    logic [DATA_W-1:0] rdata;
    logic rsel_mem;
  } core_t;

  localparam core_t CORE_RST = '{
    st: ST_IDLE,
    op: ROTATE_LEFT_OP,
    addr: '0,
    tgt: TARGET_ACC,
    acc: ACC_RST,
    arith_out_bit: 1'b0,
    nibble_out_bit: 1'b0,
    all_bits_nil_flag: 1'b0,
    powerdown_flag: POWERDOWN_RST,
    watchdog_expiry_flag: EXPIRY_RST,
    dir: DIR_RST,
    watchdog_counter: WATCHDOG_RST,
    presc: PRESC_RST,
    watchdog_enable: 1'b1,
    wake_sync: 2'b00,
    ready: 1'b1,
    done: 1'b0,
    halt: 1'b0,
    rdata: 8'h00,
    rsel_mem: 1'b0
  };

  core_t cur_q;
  core_t nxt_d;

  // memory port controls
  logic mem_we;
  logic [FILE_AW-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic mem_re_a;
  logic [FILE_AW-1:0] mem_raddr_a;
  logic [DATA_W-1:0] mem_rdata_a;
  logic mem_re_b;
  logic [DATA_W-1:0] mem_rdata_b;

  // datapath temporaries
  logic bus_file;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0] sum;
  logic [4:0] low_sum;
  logic [DATA_W-1:0] xl;

  file_ram #(
    .DW(DATA_W),
    .AW(FILE_AW)
  ) u_file_ram (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_re_a(mem_re_a),
    .i_raddr_a(mem_raddr_a),
    .o_rdata_a(mem_rdata_a),
    .i_re_b(mem_re_b),
    .i_raddr_b(I_ADDR[FILE_AW-1:0]),
    .o_rdata_b(mem_rdata_b)
  );

  always_comb begin
    nxt_d = cur_q;
    nxt_d.done = 1'b0;
    nxt_d.wake_sync = {cur_q.wake_sync[0], I_WAKE};
    bus_file = (I_ADDR[7:5] == FILE_REGION);
    mem_we = 1'b0;
    mem_waddr = I_ADDR[FILE_AW-1:0];
    mem_wdata = I_WDATA;
    mem_re_a = 1'b0;
    mem_raddr_a = I_OP_ADDR;
    mem_re_b = I_RD && bus_file;
    opnd = mem_rdata_a;
    res = opnd;
    sum = {1'b0, opnd} + {1'b0, ~cur_q.acc} + 9'h001;
    low_sum = {1'b0, opnd[3:0]} + {1'b0, ~cur_q.acc[3:0]} + 5'h01;
    xl = I_OP_LITERAL ^ cur_q.acc;

    // watchdog runs only while the oscillator is up
    if (cur_q.st != ST_SLEEP && cur_q.watchdog_enable) begin
      nxt_d.presc = cur_q.presc + 8'h01;
      if (cur_q.presc == 8'hFF) begin
        nxt_d.watchdog_counter = cur_q.watchdog_counter + 8'h01;
      end
    end

    // software writes come first so datapath register updates in the same cycle win; a datapath file write waits for software
    if (I_WR) begin
      if (bus_file) begin
        mem_we = 1'b1;
      end else begin
        case (I_ADDR)
          ACC_OFS: begin
            nxt_d.acc = I_WDATA;
          end
          STATUS_OFS: begin
            nxt_d.arith_out_bit = I_WDATA[ARITH_OUT_POS];
            nxt_d.nibble_out_bit = I_WDATA[NIBBLE_OUT_POS];
            nxt_d.all_bits_nil_flag = I_WDATA[NIL_POS];
          end
          DIR_OFS: begin
            nxt_d.dir = I_WDATA;
          end
          CTRL_OFS: begin
            nxt_d.watchdog_enable = I_WDATA[0];
          end
          default: begin
          end
        endcase
      end
    end

    // read data for the cycle after the strobe
    nxt_d.rsel_mem = I_RD && bus_file;
    nxt_d.rdata = 8'h00;
    if (I_RD && !bus_file) begin
      case (I_ADDR)
        ACC_OFS: nxt_d.rdata = cur_q.acc;
        STATUS_OFS: nxt_d.rdata = {3'b000, cur_q.watchdog_expiry_flag, cur_q.powerdown_flag,
                                   cur_q.all_bits_nil_flag, cur_q.nibble_out_bit, cur_q.arith_out_bit};
        DIR_OFS: nxt_d.rdata = cur_q.dir;
        WATCHDOG_OFS: nxt_d.rdata = cur_q.watchdog_counter;
        PRESC_OFS: nxt_d.rdata = cur_q.presc;
        CTRL_OFS: nxt_d.rdata = {7'h00, cur_q.watchdog_enable};
        default: nxt_d.rdata = 8'h00;
      endcase
    end

    case (cur_q.st)
      ST_IDLE: begin
        if (I_OP_VALID) begin
          nxt_d.op = I_OP;
          nxt_d.addr = I_OP_ADDR;
          nxt_d.tgt = I_OP_TARGET;
          case (I_OP)
            ROTATE_LEFT_OP, ROTATE_RIGHT_OP, SUBTRACT_ACC_FROM_FILE, NIBBLE_EXCHANGE_OP, XOR_FILE_OP: begin
              mem_re_a = 1'b1;
              nxt_d.st = ST_EXEC;
              nxt_d.ready = 1'b0;
            end
            DIRECTION_LOAD_OP: begin
              if (I_OP_ADDR == DIR_OPERAND) begin
                nxt_d.dir = cur_q.acc;
              end
              nxt_d.done = 1'b1;
            end
            XOR_LITERAL_OP: begin
              nxt_d.acc = xl;
              nxt_d.all_bits_nil_flag = (xl == 8'h00);
              nxt_d.done = 1'b1;
            end
            POWER_DOWN_OP: begin
              nxt_d.watchdog_counter = WATCHDOG_RST;
              nxt_d.presc = PRESC_RST;
              nxt_d.watchdog_expiry_flag = 1'b1;
              nxt_d.powerdown_flag = 1'b0;
              nxt_d.halt = 1'b1;
              nxt_d.st = ST_SLEEP;
              nxt_d.ready = 1'b0;
              nxt_d.done = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_EXEC: begin
        case (cur_q.op)
          ROTATE_LEFT_OP: begin
            res = {opnd[6:0], cur_q.arith_out_bit};
            nxt_d.arith_out_bit = opnd[7];
          end
          ROTATE_RIGHT_OP: begin
            res = {cur_q.arith_out_bit, opnd[7:1]};
            nxt_d.arith_out_bit = opnd[0];
          end
          SUBTRACT_ACC_FROM_FILE: begin
            res = sum[7:0];
            nxt_d.arith_out_bit = sum[8];
            nxt_d.nibble_out_bit = low_sum[4];
            nxt_d.all_bits_nil_flag = (sum[7:0] == 8'h00);
          end
          NIBBLE_EXCHANGE_OP: begin
            res = {opnd[3:0], opnd[7:4]};
          end
          XOR_FILE_OP: begin
            res = opnd ^ cur_q.acc;
            nxt_d.all_bits_nil_flag = (res == 8'h00);
          end
          default: begin
            res = opnd;
          end
        endcase
        if (cur_q.tgt == TARGET_ACC) begin
          nxt_d.acc = res;
          nxt_d.st = ST_IDLE;
          nxt_d.ready = 1'b1;
          nxt_d.done = 1'b1;
        end else if (!(I_WR && bus_file)) begin
          mem_we = 1'b1;
          mem_waddr = cur_q.addr;
          mem_wdata = res;
          nxt_d.st = ST_IDLE;
          nxt_d.ready = 1'b1;
          nxt_d.done = 1'b1;
        end else begin
          // software owns the write port this cycle; retry with flags untouched
          nxt_d.arith_out_bit = cur_q.arith_out_bit;
          nxt_d.nibble_out_bit = cur_q.nibble_out_bit;
          nxt_d.all_bits_nil_flag = cur_q.all_bits_nil_flag;
        end
      end
      ST_SLEEP: begin
        if (cur_q.wake_sync[1]) begin
          nxt_d.halt = 1'b0;
          nxt_d.st = ST_IDLE;
          nxt_d.ready = 1'b1;
        end
      end
      default: begin
        nxt_d.st = ST_IDLE;
        nxt_d.ready = 1'b1;
        nxt_d.halt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cur_q <= CORE_RST;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign O_RDATA = cur_q.rsel_mem ? mem_rdata_b : cur_q.rdata;
  assign O_ACC = cur_q.acc;
  assign O_STATUS = {3'b000, cur_q.watchdog_expiry_flag, cur_q.powerdown_flag,
                     cur_q.all_bits_nil_flag, cur_q.nibble_out_bit, cur_q.arith_out_bit};
  assign O_DIR = cur_q.dir;
  assign O_OSC_HALT = cur_q.halt;
  assign O_READY = cur_q.ready;
  assign O_DONE = cur_q.done;

endmodule

// *** design/file_ram.sv ***
// Purpose: file register space, one write port and two read ports
// Assumes: read data is registered and valid the cycle after the enable
// Notes: read data holds its value while the enable is low
`timescale 1ns/1ps
module file_ram #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // read port a
  input wire logic i_re_a,
  input wire logic [AW-1:0] i_raddr_a,
  output logic [DW-1:0] o_rdata_a,
  // read port b
  input wire logic i_re_b,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [DW-1:0] o_rdata_b
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
    end else begin
      if (i_re_a) begin
        o_rdata_a <= mem[i_raddr_a];
      end
      if (i_re_b) begin
        o_rdata_b <= mem[i_raddr_b];
      end
    end
  end

endmodule

// *** shared/file_alu_pkg.sv ***
// Purpose: shared constants and types for the file register datapath
// Assumes: 8-bit data, 32-entry file register space
// Notes: register offsets index byte-wide registers on the plain bus port
package file_alu_pkg;

  localparam int DATA_W = 8;
  localparam int FILE_AW = 5;
  localparam int BUS_AW = 8;

  // bus register offsets
  localparam logic [7:0] ACC_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h01;
  localparam logic [7:0] DIR_OFS = 8'h02;
  localparam logic [7:0] WATCHDOG_OFS = 8'h03;
  localparam logic [7:0] PRESC_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h05;
  // file registers sit where the top three address bits equal this region code
  localparam logic [2:0] FILE_REGION = 3'h1;

  // status bit positions
  localparam int ARITH_OUT_POS = 0;
  localparam int NIBBLE_OUT_POS = 1;
  localparam int NIL_POS = 2;
  localparam int POWERDOWN_POS = 3;
  localparam int EXPIRY_POS = 4;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] WATCHDOG_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic POWERDOWN_RST = 1'b1;
  localparam logic EXPIRY_RST = 1'b1;

  // direction load only accepts this operand
  localparam logic [4:0] DIR_OPERAND = 5'h06;
  // result target encodings
  localparam logic TARGET_ACC = 1'b0;
  localparam logic TARGET_FILE = 1'b1;

  typedef enum logic [2:0] {
    ROTATE_LEFT_OP = 3'b000,
    ROTATE_RIGHT_OP = 3'b001,
    SUBTRACT_ACC_FROM_FILE = 3'b010,
    NIBBLE_EXCHANGE_OP = 3'b011,
    DIRECTION_LOAD_OP = 3'b100,
    XOR_LITERAL_OP = 3'b101,
    XOR_FILE_OP = 3'b110,
    POWER_DOWN_OP = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SLEEP = 2'b10
  } state_t;

endpackage

// *** test/file_alu_checker.sv ***
// Purpose: port assertions for the file register datapath
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every file_alu instance
`timescale 1ns/1ps
module file_alu_checker
  import file_alu_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // operation and wake inputs
  input wire logic I_OP_VALID,
  input wire file_alu_pkg::op_t I_OP,
  input wire logic [4:0] I_OP_ADDR,
  input wire logic I_OP_TARGET,
  input wire logic [7:0] I_OP_LITERAL,
  input wire logic I_WAKE,
  // datapath outputs
  input wire logic [7:0] O_ACC,
  input wire logic [7:0] O_STATUS,
  input wire logic [7:0] O_DIR,
  input wire logic O_OSC_HALT,
  input wire logic O_READY,
  input wire logic O_DONE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  logic take;
  assign take = I_OP_VALID && O_READY;
  a_xorl_value: assert property (take && I_OP == XOR_LITERAL_OP
    |=> O_ACC == ($past(O_ACC) ^ $past(I_OP_LITERAL)))
    else $error("xor literal result wrong");
  a_xorl_nil: assert property (take && I_OP == XOR_LITERAL_OP |=> O_STATUS[2] == (O_ACC == 8'h00))
    else $error("xor literal zero flag wrong");
  a_dir_copy: assert property (take && I_OP == DIRECTION_LOAD_OP && I_OP_ADDR == DIR_OPERAND
    |=> O_DIR == $past(O_ACC))
    else $error("direction register not loaded");
  a_dir_flags: assert property (take && I_OP == DIRECTION_LOAD_OP |=> $stable(O_STATUS) && O_DONE)
    else $error("direction load touched flags");
  a_sleep_enter: assert property (take && I_OP == POWER_DOWN_OP
    |=> O_OSC_HALT && O_STATUS[4:3] == 2'b10 && !O_READY)
    else $error("power-down entry wrong");
  a_halt_hold: assert property (O_OSC_HALT && !I_WAKE && !$past(I_WAKE) && !$past(I_WAKE, 2) |=> O_OSC_HALT)
    else $error("left power-down without wake");
  a_file_timing: assert property (take && (I_OP <= NIBBLE_EXCHANGE_OP || I_OP == XOR_FILE_OP) && !I_OP_TARGET
    |=> !O_READY ##1 O_DONE && O_READY)
    else $error("file op timing wrong");
  a_swap_flags: assert property (take && I_OP == NIBBLE_EXCHANGE_OP |-> ##2 O_STATUS == $past(O_STATUS, 2))
    else $error("nibble exchange touched flags");
  a_rotate_flags: assert property (take && I_OP <= ROTATE_RIGHT_OP
    |-> ##2 O_STATUS[7:1] == $past(O_STATUS[7:1], 2))
    else $error("rotate touched other flags");
endmodule

bind file_alu file_alu_checker u_chk (.I_CLK, .I_RST_B, .I_OP_VALID, .I_OP, .I_OP_ADDR, .I_OP_TARGET,
  .I_OP_LITERAL, .I_WAKE, .O_ACC, .O_STATUS, .O_DIR, .O_OSC_HALT, .O_READY, .O_DONE);

// *** test/op_source.sv ***
// Purpose: decoder model presenting one operation at a time
// Assumes: an operation is taken at an edge with ready high
// Notes: released address, target and literal fields show inverted values so stale data cannot pass
`timescale 1ns/1ps
module op_source
  import file_alu_pkg::*;
(
  // clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  // operation fields
  output logic o_valid,
  output file_alu_pkg::op_t o_op,
  output logic [4:0] o_addr,
  output logic o_tgt,
  output logic [7:0] o_lit
);
  initial begin
    o_valid = 1'b0;
    o_op = ROTATE_LEFT_OP;
    o_addr = 5'h00;
    o_tgt = 1'b0;
    o_lit = 8'h00;
  end
  // hold keeps valid up so a follower can go in the next cycle
  task automatic issue(input op_t op, input logic [4:0] a, input logic t, input logic [7:0] k, input bit hold);
    o_valid <= 1'b1;
    o_op <= op;
    o_addr <= a;
    o_tgt <= t;
    o_lit <= k;
    // hold the request until an edge at which ready is seen high
    do @(posedge i_clk); while (i_ready !== 1'b1);
    if (!hold) begin
      o_valid <= 1'b0;
      o_addr <= ~a;
      o_tgt <= ~t;
      o_lit <= ~k;
    end
  endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the file register datapath
// Assumes: tasks are entered right after a rising edge
// Notes: file registers used by rows sit at bus offsets 20 upward
`timescale 1ns/1ps
module tb_top;
  import file_alu_pkg::*;
  typedef struct {op_t op; logic t; logic [7:0] f; logic [7:0] a; logic [2:0] si; logic [7:0] r; logic [2:0] so;} row_t;
  row_t rows[13] = '{
    '{ROTATE_LEFT_OP, 1'b0, 8'h81, 8'h00, 3'b110, 8'h02, 3'b111},
    '{ROTATE_LEFT_OP, 1'b1, 8'h40, 8'h00, 3'b001, 8'h81, 3'b000},
    '{ROTATE_RIGHT_OP, 1'b0, 8'h01, 8'h00, 3'b000, 8'h00, 3'b001},
    '{ROTATE_RIGHT_OP, 1'b1, 8'h80, 8'h00, 3'b111, 8'hC0, 3'b110},
    '{SUBTRACT_ACC_FROM_FILE, 1'b0, 8'h05, 8'h05, 3'b000, 8'h00, 3'b111},
    '{SUBTRACT_ACC_FROM_FILE, 1'b1, 8'h10, 8'h01, 3'b000, 8'h0F, 3'b001},
    '{SUBTRACT_ACC_FROM_FILE, 1'b0, 8'h01, 8'h02, 3'b111, 8'hFF, 3'b000},
    '{NIBBLE_EXCHANGE_OP, 1'b0, 8'hA5, 8'h00, 3'b101, 8'h5A, 3'b101},
    '{NIBBLE_EXCHANGE_OP, 1'b1, 8'h3C, 8'h00, 3'b010, 8'hC3, 3'b010},
    '{XOR_FILE_OP, 1'b0, 8'h55, 8'h55, 3'b011, 8'h00, 3'b111},
    '{XOR_FILE_OP, 1'b1, 8'hF0, 8'h0F, 3'b100, 8'hFF, 3'b000},
    '{XOR_LITERAL_OP, 1'b0, 8'hFF, 8'hFF, 3'b000, 8'h00, 3'b100},
    '{XOR_LITERAL_OP, 1'b0, 8'h80, 8'h01, 3'b100, 8'h81, 3'b000}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic valid, tgt, wake = 1'b0, wr = 1'b0, rd = 1'b0, halt, ready, done;
  op_t op;
  logic [4:0] addr;
  logic [7:0] lit, baddr = 8'h00, wdata = 8'h00, rdata, acc, status, dir, d;
  int n_errors = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  op_source u_src (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_op(op), .o_addr(addr), .o_tgt(tgt), .o_lit(lit));
  file_alu dut (.I_CLK(clk), .I_RST_B(rst_b), .I_OP_VALID(valid), .I_OP(op), .I_OP_ADDR(addr), .I_OP_TARGET(tgt),
    .I_OP_LITERAL(lit), .I_WAKE(wake), .I_ADDR(baddr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_ACC(acc), .O_STATUS(status), .O_DIR(dir), .O_OSC_HALT(halt), .O_READY(ready), .O_DONE(done));
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    wr <= 1'b1;
    baddr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    rd <= 1'b1;
    baddr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  // bounded wait on a level, sampled away from the launching edge
  task automatic wait_for(ref logic s, input logic lvl);
    for (int n = 0; n < 8 && s !== lvl; n++) @(negedge clk);
    check({7'h00, s}, {7'h00, lvl}, "handshake");
    @(posedge clk);
  endtask
  initial begin
    #(25ns * 5000);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(acc, ACC_RST, "acc reset");
    check(dir, DIR_RST, "dir reset");
    check(status, 8'h18, "status reset");
    foreach (rows[i]) begin
      bus_wr(8'h20 + 8'(i), rows[i].f);
      bus_wr(ACC_OFS, rows[i].a);
      bus_wr(STATUS_OFS, {5'h00, rows[i].si});
      u_src.issue(rows[i].op, 5'(i), rows[i].t, rows[i].f, 1'b0);
      wait_for(done, 1'b1);
      bus_rd(rows[i].t ? 8'h20 + 8'(i) : ACC_OFS, d);
      check(d, rows[i].r, "result");
      check({5'h00, status[2:0]}, {5'h00, rows[i].so}, "flags");
      if (rows[i].t) check(acc, rows[i].a, "acc kept");
    end
    bus_rd(8'h10, d);
    check(d, 8'h00, "unmapped read");
    bus_wr(ACC_OFS, 8'h5A);
    u_src.issue(DIRECTION_LOAD_OP, 5'h07, 1'b0, 8'h00, 1'b0);
    wait_for(done, 1'b1);
    check(dir, 8'hFF, "dir wrong operand");
    u_src.issue(DIRECTION_LOAD_OP, DIR_OPERAND, 1'b0, 8'h00, 1'b0);
    wait_for(done, 1'b1);
    check(dir, 8'h5A, "dir load");
    bus_wr(ACC_OFS, 8'h0F);
    u_src.issue(XOR_LITERAL_OP, 5'h00, 1'b0, 8'hF0, 1'b1);
    u_src.issue(XOR_LITERAL_OP, 5'h00, 1'b0, 8'hFF, 1'b0);
    wait_for(done, 1'b1);
    check(acc, 8'h00, "xor pair");
    check({7'h00, status[2]}, 8'h01, "xor pair zero");
    // let the prescaler wrap at least once so the clear below is visible
    repeat (256) @(posedge clk);
    bus_rd(WATCHDOG_OFS, d);
    check({7'h00, d != 8'h00}, 8'h01, "watchdog running");
    u_src.issue(POWER_DOWN_OP, 5'h00, 1'b0, 8'h00, 1'b0);
    wait_for(done, 1'b1);
    check({6'h00, status[4:3]}, 8'h02, "sleep flags");
    repeat (4) @(posedge clk);
    bus_rd(WATCHDOG_OFS, d);
    check(d, WATCHDOG_RST, "watchdog cleared");
    bus_rd(PRESC_OFS, d);
    check(d, PRESC_RST, "prescaler cleared");
    check({7'h00, halt}, 8'h01, "halted");
    wake <= 1'b1;
    wait_for(halt, 1'b0);
    wake <= 1'b0;
    check({7'h00, ready}, 8'h01, "ready after wake");
    give_verdict();
  end
endmodule
